/* File: logic/rgc_pkg.sv */
// Package for receiver gain and carrier sense configuration registers
package rgc_pkg;
  localparam logic [5:0] OFS_FOC = 6'h19;
  localparam logic [5:0] OFS_BSYNC = 6'h1a;
  localparam logic [5:0] OFS_GLT = 6'h1b;
  localparam logic [5:0] OFS_GOCS = 6'h1c;
  localparam logic [5:0] OFS_TUNE = 6'h1d;
  localparam logic [5:0] RST_FOC = 6'h36;
  localparam logic [7:0] RST_BSYNC = 8'h6c;
  localparam logic [7:0] RST_GLT = 8'h03;
  localparam logic [6:0] RST_GOCS = 7'h40;
  localparam logic [7:0] RST_TUNE = 8'h91;
  localparam int HDR_RW_BIT = 7;
  localparam int HDR_BURST_BIT = 6;
  localparam logic [3:0] ABS_OFF = 4'h8;

  typedef struct packed {
    logic [1:0] digital_gain_limit;
    logic [2:0] front_amp_gain_cap;
    logic [2:0] amplitude_target;
  } rgc_glt_t;

  typedef struct packed {
    logic gain_reduction_order;
    logic [1:0] relative_sense_threshold;
    logic [3:0] absolute_sense_threshold;
  } rgc_gocs_t;

  typedef struct packed {
    logic [5:0] foc;
    logic [7:0] bsync;
    rgc_glt_t glt;
    rgc_gocs_t gocs;
    logic [7:0] tune;
  } rgc_cfg_t;

  typedef enum logic [1:0] {ST_IDLE, ST_HDR, ST_DATA} rgc_st_t;

  function automatic logic [7:0] rgc_target_db(input logic [2:0] code);
    case (code)
      3'h0: rgc_target_db = 8'h18;
      3'h1: rgc_target_db = 8'h1b;
      3'h2: rgc_target_db = 8'h1e;
      3'h3: rgc_target_db = 8'h21;
      3'h4: rgc_target_db = 8'h24;
      3'h5: rgc_target_db = 8'h26;
      3'h6: rgc_target_db = 8'h28;
      default: rgc_target_db = 8'h2a;
    endcase
  endfunction

  // Tenths of a dB below maximum front gain
  function automatic logic [7:0] rgc_cap_tenths(input logic [2:0] code);
    case (code)
      3'h0: rgc_cap_tenths = 8'h00;
      3'h1: rgc_cap_tenths = 8'h1a;
      3'h2: rgc_cap_tenths = 8'h3d;
      3'h3: rgc_cap_tenths = 8'h4a;
      3'h4: rgc_cap_tenths = 8'h5c;
      3'h5: rgc_cap_tenths = 8'h73;
      3'h6: rgc_cap_tenths = 8'h92;
      default: rgc_cap_tenths = 8'hab;
    endcase
  endfunction

  function automatic logic [7:0] rgc_rel_db(input logic [1:0] code);
    case (code)
      2'h0: rgc_rel_db = 8'h00;
      2'h1: rgc_rel_db = 8'h06;
      2'h2: rgc_rel_db = 8'h0a;
      default: rgc_rel_db = 8'h0e;
    endcase
  endfunction

  // Trip level as signed 9-bit dB: target plus signed offset
  function automatic logic signed [8:0] rgc_trip_db(input logic [2:0] tgt, input logic [3:0] ofs);
    rgc_trip_db = $signed({1'b0, rgc_target_db(tgt)}) + $signed({{5{ofs[3]}}, ofs});
  endfunction
endpackage : rgc_pkg

/* File: logic/rgc_pin_sync.sv */
// Three-stage pin synchroniser with agreement filter
module rgc_pin_sync
  import rgc_pkg::*;
#(
  parameter logic INIT = 1'b0
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic pin,
  output logic level
);
  logic s1_r, s2_r, s3_r, level_r;
  logic level_nxt;

  // Only s2 and s3 are compared; s1 may be metastable
  always_comb begin
    level_nxt = level_r;
    if (s2_r == s3_r) begin
      level_nxt = s2_r;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_r <= INIT;
      s2_r <= INIT;
      s3_r <= INIT;
      level_r <= INIT;
    end else begin
      s1_r <= pin;
      s2_r <= s1_r;
      s3_r <= s2_r;
      level_r <= level_nxt;
    end
  end

  assign level = level_r;
endmodule // rgc_pin_sync

/* File: logic/rgc_regs.sv */
// Serial register port and gain / carrier sense configuration bank
module rgc_regs
  import rgc_pkg::*;
#(
  parameter int DGAIN_STEPS = 8
) (
  input wire logic REF_CLK,
  input wire logic RST_N,
  input wire logic SCLK,
  input wire logic CS_N,
  input wire logic SI,
  output logic SO,
  output logic SO_OE_N,
  input wire logic [7:0] RSSI_DB,
  input wire logic [7:0] RSSI_RISE_DB,
  input wire logic PKT_RX_ACTIVE,
  input wire logic [1:0] CLEAR_CHANNEL_SELECT,
  output logic [3:0] DGAIN_MAX_IDX,
  output logic [7:0] FRONT_CAP_TENTHS,
  output logic [7:0] TARGET_DB,
  output logic FIRST_AMP_FIRST,
  output logic CARRIER_SENSE,
  output logic CLEAR_CHANNEL,
  output logic [5:0] FOC_CFG,
  output logic [7:0] BSYNC_CFG,
  output logic [7:0] TUNE_CFG
);
  logic sclk_s, csn_s, si_s;

  rgc_pin_sync #(.INIT(1'b0)) u_sync_sclk (.clk(REF_CLK), .rst_n(RST_N), .pin(SCLK), .level(sclk_s));
  rgc_pin_sync #(.INIT(1'b1)) u_sync_csn (.clk(REF_CLK), .rst_n(RST_N), .pin(CS_N), .level(csn_s));
  rgc_pin_sync #(.INIT(1'b0)) u_sync_si (.clk(REF_CLK), .rst_n(RST_N), .pin(SI), .level(si_s));

  // Serial engine state
  rgc_st_t st_r, st_nxt;
  logic sclk_d_r, sclk_d_nxt;
  logic [2:0] bit_cnt_r, bit_cnt_nxt;
  logic [7:0] rx_sh_r, rx_sh_nxt;
  logic [7:0] tx_r, tx_nxt;
  logic [5:0] addr_r, addr_nxt;
  logic rd_r, rd_nxt, burst_r, burst_nxt;
  logic so_r, so_nxt, so_oe_n_r, so_oe_n_nxt;
  logic wr_en;
  logic [7:0] wr_data;
  logic rise, fall;
  logic [7:0] byte_in;

  rgc_cfg_t cfg_r, cfg_nxt;

  function automatic logic [7:0] read_mux(input rgc_cfg_t c, input logic [5:0] a);
    case (a)
      OFS_FOC: read_mux = {2'b00, c.foc};
      OFS_BSYNC: read_mux = c.bsync;
      OFS_GLT: read_mux = c.glt;
      OFS_GOCS: read_mux = {1'b0, c.gocs};
      OFS_TUNE: read_mux = c.tune;
      default: read_mux = 8'h00;
    endcase
  endfunction

  assign rise = sclk_s & ~sclk_d_r;
  assign fall = ~sclk_s & sclk_d_r;
  assign byte_in = {rx_sh_r[6:0], si_s};

  always_comb begin
    st_nxt = st_r;
    sclk_d_nxt = sclk_s;
    bit_cnt_nxt = bit_cnt_r;
    rx_sh_nxt = rx_sh_r;
    tx_nxt = tx_r;
    addr_nxt = addr_r;
    rd_nxt = rd_r;
    burst_nxt = burst_r;
    so_nxt = so_r;
    so_oe_n_nxt = csn_s;
    wr_en = 1'b0;
    wr_data = byte_in;
    if (csn_s) begin
      // Deselect aborts any partial byte
      st_nxt = ST_IDLE;
      bit_cnt_nxt = 3'h0;
      tx_nxt = 8'h00;
      so_nxt = 1'b0;
    end else begin
      if (st_r == ST_IDLE) begin
        st_nxt = ST_HDR;
      end
      if (rise) begin
        rx_sh_nxt = byte_in;
        bit_cnt_nxt = bit_cnt_r + 3'h1;
        if (bit_cnt_r == 3'h7) begin
          if (st_r == ST_DATA) begin
            wr_en = ~rd_r;
            if (burst_r) begin
              addr_nxt = addr_r + 6'h01;
            end
            tx_nxt = read_mux(cfg_r, burst_r ? addr_r + 6'h01 : addr_r);
          end else begin
            addr_nxt = byte_in[5:0];
            rd_nxt = byte_in[HDR_RW_BIT];
            burst_nxt = byte_in[HDR_BURST_BIT];
            tx_nxt = read_mux(cfg_r, byte_in[5:0]);
            st_nxt = ST_DATA;
          end
        end
      end
      // Output changes on falling edge so the host samples a stable bit
      if (fall) begin
        so_nxt = tx_r[~bit_cnt_r];
      end
    end
  end

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      st_r <= ST_IDLE;
      sclk_d_r <= 1'b0;
      bit_cnt_r <= 3'h0;
      rx_sh_r <= 8'h00;
      tx_r <= 8'h00;
      addr_r <= 6'h00;
      rd_r <= 1'b0;
      burst_r <= 1'b0;
      so_r <= 1'b0;
      so_oe_n_r <= 1'b1;
    end else begin
      st_r <= st_nxt;
      sclk_d_r <= sclk_d_nxt;
      bit_cnt_r <= bit_cnt_nxt;
      rx_sh_r <= rx_sh_nxt;
      tx_r <= tx_nxt;
      addr_r <= addr_nxt;
      rd_r <= rd_nxt;
      burst_r <= burst_nxt;
      so_r <= so_nxt;
      so_oe_n_r <= so_oe_n_nxt;
    end
  end

  // Register bank; unmapped writes are dropped
  always_comb begin
    cfg_nxt = cfg_r;
    if (wr_en) begin
      unique case (addr_r)
        OFS_FOC: cfg_nxt.foc = wr_data[5:0];
        OFS_BSYNC: cfg_nxt.bsync = wr_data;
        OFS_GLT: cfg_nxt.glt = wr_data;
        OFS_GOCS: cfg_nxt.gocs = wr_data[6:0];
        OFS_TUNE: cfg_nxt.tune = wr_data;
        default: cfg_nxt = cfg_r;
      endcase
    end
  end

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      cfg_r <= {RST_FOC, RST_BSYNC, RST_GLT, RST_GOCS, RST_TUNE};
    end else begin
      cfg_r <= cfg_nxt;
    end
  end

  // Decoded gain-loop controls and carrier sense
  logic [3:0] dg_nxt, dg_r;
  logic [7:0] cap_nxt, cap_r, tgt_nxt, tgt_r;
  logic order_nxt, order_r, abs_hit, rel_hit, cs_nxt, cs_r, cca_nxt, cca_r;

  always_comb begin
    dg_nxt = 4'(DGAIN_STEPS - 1) - {2'b00, cfg_r.glt.digital_gain_limit};
    cap_nxt = rgc_cap_tenths(cfg_r.glt.front_amp_gain_cap);
    tgt_nxt = rgc_target_db(cfg_r.glt.amplitude_target);
    order_nxt = cfg_r.gocs.gain_reduction_order;
    // Compared against unreduced-gain level supplied by the loop
    abs_hit = (cfg_r.gocs.absolute_sense_threshold != ABS_OFF) &&
              ($signed({1'b0, RSSI_DB}) >= rgc_trip_db(cfg_r.glt.amplitude_target,
                                                       cfg_r.gocs.absolute_sense_threshold));
    rel_hit = (cfg_r.gocs.relative_sense_threshold != 2'h0) &&
              (RSSI_RISE_DB >= rgc_rel_db(cfg_r.gocs.relative_sense_threshold));
    cs_nxt = abs_hit | rel_hit;
    unique case (CLEAR_CHANNEL_SELECT)
      2'h0: cca_nxt = 1'b1;
      2'h1: cca_nxt = ~cs_nxt;
      2'h2: cca_nxt = ~PKT_RX_ACTIVE;
      2'h3: cca_nxt = ~cs_nxt & ~PKT_RX_ACTIVE;
    endcase
  end

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      dg_r <= 4'h0;
      cap_r <= 8'h00;
      tgt_r <= 8'h00;
      order_r <= 1'b0;
      cs_r <= 1'b0;
      cca_r <= 1'b0;
    end else begin
      dg_r <= dg_nxt;
      cap_r <= cap_nxt;
      tgt_r <= tgt_nxt;
      order_r <= order_nxt;
      cs_r <= cs_nxt;
      cca_r <= cca_nxt;
    end
  end

  assign SO = so_r;
  assign SO_OE_N = so_oe_n_r;
  assign DGAIN_MAX_IDX = dg_r;
  assign FRONT_CAP_TENTHS = cap_r;
  assign TARGET_DB = tgt_r;
  assign FIRST_AMP_FIRST = order_r;
  assign CARRIER_SENSE = cs_r;
  assign CLEAR_CHANNEL = cca_r;
  assign FOC_CFG = cfg_r.foc;
  assign BSYNC_CFG = cfg_r.bsync;
  assign TUNE_CFG = cfg_r.tune;

  // Skips the edge after release, where the output flop still held its reset value
  a_dgain_limit_idx: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    $past(RST_N) |-> DGAIN_MAX_IDX == 4'(DGAIN_STEPS - 1) - {2'b00, $past(cfg_r.glt.digital_gain_limit)})
    else $error("digital gain limit index wrong");
  a_front_cap_map: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    $past(cfg_r.glt.front_amp_gain_cap) == 3'h7 |-> FRONT_CAP_TENTHS == 8'hab)
    else $error("front cap code 7 not 17.1 dB");
  a_target_db_map: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    $past(cfg_r.glt.amplitude_target) == 3'h0 |-> TARGET_DB == 8'h18)
    else $error("target code 0 not 24 dB");
  a_gain_order_follow: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    $changed(cfg_r.gocs.gain_reduction_order) |=> FIRST_AMP_FIRST == $past(cfg_r.gocs.gain_reduction_order))
    else $error("gain order output stale");
  a_rel_sense_off: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    (cfg_r.gocs.relative_sense_threshold == 2'h0 && cfg_r.gocs.absolute_sense_threshold == ABS_OFF)
    |=> !CARRIER_SENSE)
    else $error("carrier sense with both detectors off");
  a_rel_sense_trip: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    (cfg_r.gocs.relative_sense_threshold == 2'h1 && RSSI_RISE_DB >= 8'h06) |=> CARRIER_SENSE)
    else $error("6 dB rise missed");
  a_abs_trip_point: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    (cfg_r.gocs.absolute_sense_threshold == 4'h1 && cfg_r.gocs.relative_sense_threshold == 2'h0)
    |=> CARRIER_SENSE == ($past(RSSI_DB) >= $past(rgc_target_db(cfg_r.glt.amplitude_target)) + 8'h01))
    else $error("absolute trip point not target plus 1 dB");
  a_foc_reserved: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    (wr_en && addr_r == OFS_FOC) |=> cfg_r.foc == $past(wr_data[5:0]))
    else $error("frequency offset field write wrong");
  a_clear_gated: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    (CLEAR_CHANNEL_SELECT == 2'h3 && PKT_RX_ACTIVE) |=> !CLEAR_CHANNEL)
    else $error("clear channel during packet reception");
  a_so_released: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    csn_s |=> SO_OE_N && !SO)
    else $error("serial output driven while deselected");
endmodule // rgc_regs

/* File: bench/rgc_host.sv */
// Host side serial register port master model
module rgc_host (
  input wire logic clk,
  output logic sclk,
  output logic cs_n,
  output logic si,
  input wire logic so
);
  timeunit 1ns;
  timeprecision 1ps;
  // Serial clock high phase lasts 10 device clocks and low phase 11, above the 8-cycle minimum
  localparam int HALF = 10;
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    si = 1'b0;
  end
  // Header byte then nb-1 data bytes, left aligned in sh, MSB first, mode 0
  task automatic xfer(input int nb, input logic [23:0] sh, output logic [15:0] rd);
    rd = 16'h0000;
    @(posedge clk);
    cs_n <= 1'b0;
    for (int i = 23; i >= 24 - 8 * nb; i--) begin
      @(posedge clk);
      si <= sh[i];
      repeat (HALF) @(posedge clk);
      if (i < 16) begin
        rd = {rd[14:0], so};
      end
      sclk <= 1'b1;
      repeat (HALF) @(posedge clk);
      sclk <= 1'b0;
    end
    repeat (HALF) @(posedge clk);
    cs_n <= 1'b1;
    // Released data line must not keep its last level
    si <= ~si;
    repeat (HALF) @(posedge clk);
  endtask
endmodule // rgc_host

/* File: bench/tb_top.sv */
// Self-checking bench for the gain and carrier sense register bank
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin mismatches++; $display("[ERR] %s exp %h got %h", nm, e, g); end end
module tb_top
  import rgc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic wr; logic [5:0] ofs; logic [7:0] wd; logic [7:0] rd;} rgc_row_t;
  localparam int DG = 8;
  logic ref_clk, sclk, cs_n, si, so, so_oe_n, faf, csense, cchan;
  logic rst_n = 1'b0;
  logic pkt = 1'b0;
  logic [1:0] sel = 2'h0;
  logic [7:0] rssi = 8'h00;
  logic [7:0] rise = 8'h00;
  logic [7:0] cap, tgt, bsync, tune, rd;
  logic [15:0] rdw;
  logic [3:0] dgain;
  logic [5:0] foc;
  int mismatches = 0;
  int compares = 0;
  rgc_row_t rows [11] = '{{1'b0, 6'h19, 8'h00, 8'h36}, {1'b0, 6'h1a, 8'h00, 8'h6c}, {1'b0, 6'h1b, 8'h00, 8'h03},
    {1'b0, 6'h1c, 8'h00, 8'h40}, {1'b0, 6'h1d, 8'h00, 8'h91}, {1'b1, 6'h19, 8'hff, 8'h3f},
    {1'b1, 6'h1a, 8'ha5, 8'ha5}, {1'b1, 6'h1b, 8'hc9, 8'hc9}, {1'b1, 6'h1c, 8'hbf, 8'h3f},
    {1'b1, 6'h1d, 8'h5a, 8'h5a}, {1'b1, 6'h25, 8'h77, 8'h00}};
  logic [7:0] cap_tab [8] = '{8'h00, 8'h1a, 8'h3d, 8'h4a, 8'h5c, 8'h73, 8'h92, 8'hab};
  logic [7:0] tgt_tab [8] = '{8'h18, 8'h1b, 8'h1e, 8'h21, 8'h24, 8'h26, 8'h28, 8'h2a};
  logic [7:0] rel_tab [4] = '{8'h00, 8'h06, 8'h0a, 8'h0e};

  rgc_regs #(.DGAIN_STEPS(DG)) rgc_regs_i (.REF_CLK(ref_clk), .RST_N(rst_n), .SCLK(sclk), .CS_N(cs_n), .SI(si),
    .SO(so), .SO_OE_N(so_oe_n), .RSSI_DB(rssi), .RSSI_RISE_DB(rise), .PKT_RX_ACTIVE(pkt),
    .CLEAR_CHANNEL_SELECT(sel), .DGAIN_MAX_IDX(dgain), .FRONT_CAP_TENTHS(cap), .TARGET_DB(tgt),
    .FIRST_AMP_FIRST(faf), .CARRIER_SENSE(csense), .CLEAR_CHANNEL(cchan), .FOC_CFG(foc), .BSYNC_CFG(bsync),
    .TUNE_CFG(tune));
  rgc_host rgc_host_i (.clk(ref_clk), .sclk(sclk), .cs_n(cs_n), .si(si), .so(so));

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    rgc_host_i.xfer(2, {2'b00, a, d, 8'h00}, rdw);
  endtask

  task automatic rdreg(input logic [5:0] a);
    rgc_host_i.xfer(2, {2'b10, a, 16'h0000}, rdw);
    rd = rdw[7:0];
  endtask

  // Sense output is one cycle behind; two edges leave margin
  task automatic sense(input logic [7:0] db, input logic [7:0] up, input logic [1:0] s, input logic p,
                       input logic ecs, input logic ecc);
    @(posedge ref_clk);
    rssi <= db;
    rise <= up;
    sel <= s;
    pkt <= p;
    repeat (2) @(posedge ref_clk);
    #1;
    `CHK("carrier_sense", ecs, csense)
    `CHK("clear_channel", ecc, cchan)
  endtask

  task automatic conclude;
    if (mismatches == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    repeat (8) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (6) @(posedge ref_clk);
    foreach (rows[i]) begin
      if (rows[i].wr) begin
        wr(rows[i].ofs, rows[i].wd);
      end
      rdreg(rows[i].ofs);
      `CHK("readback", rows[i].rd, rd)
    end
    `CHK("foc_out", 6'h3f, foc)
    `CHK("bsync_out", 8'ha5, bsync)
    `CHK("tune_out", 8'h5a, tune)
    // Second reset in mid-run must restore defaults
    rst_n <= 1'b0;
    @(posedge ref_clk);
    #1;
    `CHK("so_rst", 1'b0, so)
    `CHK("so_oe_rst", 1'b1, so_oe_n)
    `CHK("foc_rst", 6'h36, foc)
    `CHK("bsync_rst", 8'h6c, bsync)
    `CHK("tune_rst", 8'h91, tune)
    @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (6) @(posedge ref_clk);
    #1;
    `CHK("dgain_rst", 4'h7, dgain)
    `CHK("target_rst", 8'h21, tgt)
    `CHK("order_rst", 1'b1, faf)
    // Every code of each field except the absolute threshold (held at off), with relative threshold just below and at its step
    for (int k = 0; k < 8; k++) begin
      wr(OFS_GLT, {k[1:0], k[2:0], k[2:0]});
      wr(OFS_GOCS, {1'b0, k[2], k[1:0], ABS_OFF});
      `CHK("dgain", 4'(DG - 1 - (k % 4)), dgain)
      `CHK("cap", cap_tab[k], cap)
      `CHK("target", tgt_tab[k], tgt)
      `CHK("order", k[2], faf)
      sense(8'hff, (k % 4 == 0) ? 8'hff : rel_tab[k % 4] - 8'h01, 2'h1, 1'b0, 1'b0, 1'b1);
      sense(8'h00, rel_tab[k % 4], 2'h1, 1'b0, k % 4 != 0, k % 4 == 0);
    end
    // Target 27 dB, offset -1, relative 14 dB
    wr(OFS_GLT, 8'h09);
    wr(OFS_GOCS, 8'h3f);
    sense(8'h19, 8'h0d, 2'h1, 1'b0, 1'b0, 1'b1);
    sense(8'h1a, 8'h0d, 2'h1, 1'b0, 1'b1, 1'b0);
    sense(8'h00, 8'h0e, 2'h3, 1'b1, 1'b1, 1'b0);
    sense(8'h00, 8'h00, 2'h3, 1'b1, 1'b0, 1'b0);
    sense(8'h00, 8'h00, 2'h2, 1'b0, 1'b0, 1'b1);
    sense(8'h1e, 8'h00, 2'h0, 1'b1, 1'b1, 1'b1);
    // Offset +7 puts the trip point at 34 dB
    wr(OFS_GOCS, 8'h17);
    sense(8'h22, 8'h05, 2'h1, 1'b0, 1'b1, 1'b0);
    sense(8'h21, 8'h05, 2'h1, 1'b0, 1'b0, 1'b1);
    sense(8'h21, 8'h06, 2'h1, 1'b0, 1'b1, 1'b0);
    // Burst write then burst read across two registers
    rgc_host_i.xfer(3, {2'b01, OFS_GOCS, 8'h01, 8'h3c}, rdw);
    `CHK("tune_burst", 8'h3c, tune)
    fork
      rgc_host_i.xfer(3, {2'b11, OFS_GOCS, 16'h0000}, rdw);
      begin
        repeat (40) @(posedge ref_clk);
        #1;
        `CHK("so_oe_sel", 1'b0, so_oe_n)
      end
    join
    `CHK("burst_read", 16'h013c, rdw)
    // Offset +1 alone puts the trip point at 28 dB; relative detection off
    sense(8'h1c, 8'hff, 2'h1, 1'b0, 1'b1, 1'b0);
    sense(8'h1b, 8'hff, 2'h1, 1'b0, 1'b0, 1'b1);
    conclude();
  end
endmodule // tb_top
